// *** dp_lvds_regs.svh ***
/*
  Constants of the DP-to-LVDS pixel packer: DPCD addresses, field positions,
  reset values and start-up timing.
  Assumes it is included by its bare name from the design.
*/
`ifndef DP_LVDS_REGS_SVH
`define DP_LVDS_REGS_SVH

// ==========================================================================
// DPCD addresses (20-bit AUX address space).
`define DPCD_REV_ADDR          20'h00000
`define DPCD_MAX_LANE_ADDR     20'h00002
`define DPCD_SPREAD_CAP_ADDR   20'h00003
`define DPCD_EDP_CAP_ADDR      20'h0000D
`define DPCD_LANE_SET_ADDR     20'h00101
`define DPCD_SPREAD_CTRL_ADDR  20'h00107
`define DPCD_EDP_SET_ADDR      20'h0010A
`define DPCD_VENDOR_BASE       20'h00510
`define VND_LVDS_CFG_OFS       20'h00000
`define VND_STRAP_STAT_OFS     20'h00001

// ==========================================================================
// Fixed read values and field positions.
`define DPCD_REV_VAL           8'h12
`define DPCD_SPREAD_CAP_VAL    8'h01
`define DPCD_EDP_CAP_VAL       8'h01
`define LANE_ENH_FRAME_BIT     7
`define EDP_SET_ALTERNATE_SEED_RESET_BIT       0
`define LVDS_CFG_DUAL_BIT      0
`define LVDS_CFG_FMT_LSB       1
`define LVDS_CFG_OVR_BIT       3
`define LVDS_CFG_SPREAD_BIT    4

// ==========================================================================
// Reset values and the LVDS clock word.
`define SPREAD_CTRL_RST        8'h00
`define EDP_SET_RST            8'h00
`define LANE_SET_RST           8'h00
`define LVDS_CFG_RST           8'h00
`define LVDS_CLK_WORD          7'h63

// ==========================================================================
// Timing: clock rate and longest start-up time before hot-plug rises.
`define CLK_HZ                 64'd25000000
`define INIT_TIME_MS           64'd90
`define INIT_CYCLES            32'((`INIT_TIME_MS * `CLK_HZ) / 64'd1000)
`define STRAP_SAMPLE_CYC       32'h00000003

`endif

// *** dp_lvds_pkg.sv ***
/*
  Types shared by the DP-to-LVDS pixel packer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dp_lvds_pkg;

  // ========================================================================
  // Pixel packing format; the code equals the three-level strap encoding.
  typedef enum logic [1:0] {
    FMT_VESA24,
    FMT_MSB24,
    FMT_DEPTH18
  } fmt_t;

  // ========================================================================
  // AUX request handler states.
  typedef enum logic {
    AUX_IDLE,
    AUX_DDC_WAIT
  } aux_state_t;

endpackage : dp_lvds_pkg

// *** dp_to_lvds_pixel_packer.sv ***
/*
  DP-to-LVDS pixel packer: strap capture, hot-plug readiness, DPCD access
  over an AUX request port, and LVDS seven-bit channel word packing.
  Assumes AUX and main-link framing are decoded upstream; pixels arrive on
  the recovered pixel clock, and serialisers consume the packed words.
*/
`include "dp_lvds_regs.svh"

module dp_to_lvds_pixel_packer
  import dp_lvds_pkg::*;
#(
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        lane_count_strap,
  input  wire logic        bus_count_strap,
  input  wire logic [1:0]  format_depth_strap,
  input  wire logic        deep_sleep_exit,
  output logic             hot_plug_output,
  output logic             lane_count_one,
  output logic             enhanced_framing_en,
  output logic             alternate_seed_reset,
  output logic             spread_enable,
  input  wire logic        aux_req,
  input  wire logic        aux_native,
  input  wire logic        aux_write,
  input  wire logic [19:0] aux_addr,
  input  wire logic [7:0]  aux_wdata,
  output logic             aux_ack,
  output logic [7:0]       aux_rdata,
  output logic             ddc_req,
  output logic             ddc_write,
  output logic [19:0]      ddc_addr,
  output logic [7:0]       ddc_wdata,
  input  wire logic        ddc_done,
  input  wire logic [7:0]  ddc_rdata,
  input  wire logic        pix_clk,
  input  wire logic        pix_valid,
  input  wire logic [7:0]  pix_red,
  input  wire logic [7:0]  pix_green,
  input  wire logic [7:0]  pix_blue,
  input  wire logic        pix_de,
  input  wire logic        pix_hsync,
  input  wire logic        pix_vsync,
  output logic             lvds_word_valid,
  output logic [27:0]      lvds_odd_word,
  output logic [27:0]      lvds_even_word,
  output logic [6:0]       lvds_clk_word
);

  // ========================================================================
  // Pin synchronisers. Straps and the wake pin are asynchronous levels.
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic       wake_prev;
  logic       wake_rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {deep_sleep_exit, format_depth_strap, bus_count_strap, lane_count_strap};
      pin_sync <= pin_meta;
    end
  end

  // Edge of the synchronised wake level; the meta stage is never read here.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_prev <= 1'b0;
    end else begin
      wake_prev <= pin_sync[4];
    end
  end
  assign wake_rise = pin_sync[4] && !wake_prev;

  // ========================================================================
  // Start-up counter: restarts at reset release and on deep-sleep exit.
  logic [31:0] init_cnt;
  logic        init_done;
  logic        strap_sample;

  assign init_done    = (init_cnt == 32'(INIT_CYCLES));
  assign strap_sample = (init_cnt == `STRAP_SAMPLE_CYC) && !wake_rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_cnt <= 32'h00000000;
    end else if (wake_rise) begin
      init_cnt <= 32'h00000000;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 32'h00000001;
    end
  end

  // Hot-plug rises only once initialisation has run to its end.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hot_plug_output <= 1'b0;
    end else begin
      hot_plug_output <= init_done && !wake_rise;
    end
  end

  // ========================================================================
  // Strap capture. Straps are sampled a few cycles after the restart so the
  // synchronisers have settled; in between, the captured values are held.
  logic strap_lane_q;
  logic strap_dual_q;
  fmt_t strap_fmt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_lane_q <= 1'b0;
      strap_dual_q <= 1'b0;
      strap_fmt_q  <= FMT_VESA24;
    end else if (strap_sample) begin
      strap_lane_q <= pin_sync[0];
      strap_dual_q <= pin_sync[1];
      strap_fmt_q  <= (pin_sync[3:2] == 2'h3) ? FMT_DEPTH18 : fmt_t'(pin_sync[3:2]);
    end
  end

  // High lane strap selects two main-link lanes; low selects four.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_count_one <= 1'b0;
    end else begin
      lane_count_one <= strap_lane_q;
    end
  end

  // ========================================================================
  // DPCD registers held by the receiver.
  logic [7:0] spread_ctrl;
  logic [7:0] edp_set;
  logic [7:0] lane_set;
  logic [7:0] lvds_cfg;
  logic       dpcd_wr;
  logic       vendor_hit;
  logic [19:0] vendor_ofs;
  aux_state_t aux_state;

  assign dpcd_wr    = aux_req && aux_native && aux_write && (aux_state == AUX_IDLE);
  assign vendor_ofs = aux_addr - `DPCD_VENDOR_BASE;
  assign vendor_hit = (aux_addr >= `DPCD_VENDOR_BASE);

  // Writes from the source; unmapped addresses ignore the data.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spread_ctrl <= `SPREAD_CTRL_RST;
      edp_set     <= `EDP_SET_RST;
      lane_set    <= `LANE_SET_RST;
      lvds_cfg    <= `LVDS_CFG_RST;
    end else if (dpcd_wr) begin
      if (aux_addr == `DPCD_SPREAD_CTRL_ADDR) begin
        spread_ctrl <= aux_wdata;
      end
      if (aux_addr == `DPCD_EDP_SET_ADDR) begin
        edp_set <= aux_wdata;
      end
      if (aux_addr == `DPCD_LANE_SET_ADDR) begin
        lane_set <= aux_wdata;
      end
      if (vendor_hit && vendor_ofs == `VND_LVDS_CFG_OFS) begin
        lvds_cfg <= aux_wdata;
      end
    end
  end

  // Read data for a native request, from fixed capabilities or live state.
  logic [7:0] dpcd_rd;

  always_comb begin
    dpcd_rd = 8'h00;
    unique case (1'b1)
      aux_addr == `DPCD_REV_ADDR:         dpcd_rd = `DPCD_REV_VAL;
      aux_addr == `DPCD_MAX_LANE_ADDR:    dpcd_rd = {1'b1, 4'h0, !strap_lane_q, strap_lane_q, 1'b0};
      aux_addr == `DPCD_SPREAD_CAP_ADDR:  dpcd_rd = `DPCD_SPREAD_CAP_VAL;
      aux_addr == `DPCD_EDP_CAP_ADDR:     dpcd_rd = `DPCD_EDP_CAP_VAL;
      aux_addr == `DPCD_LANE_SET_ADDR:    dpcd_rd = lane_set;
      aux_addr == `DPCD_SPREAD_CTRL_ADDR: dpcd_rd = spread_ctrl;
      aux_addr == `DPCD_EDP_SET_ADDR:     dpcd_rd = edp_set;
      vendor_hit && vendor_ofs == `VND_LVDS_CFG_OFS:   dpcd_rd = lvds_cfg;
      vendor_hit && vendor_ofs == `VND_STRAP_STAT_OFS:
        dpcd_rd = {4'h0, strap_fmt_q, strap_dual_q, strap_lane_q};
      default: dpcd_rd = 8'h00;
    endcase
  end

  // ========================================================================
  // AUX handler. Native requests answer next cycle; I2C-over-AUX requests
  // go out to the DDC master and answer when it reports done. Requests
  // arriving while a DDC transfer is pending are ignored.

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aux_state <= AUX_IDLE;
      aux_ack   <= 1'b0;
      aux_rdata <= 8'h00;
      ddc_req   <= 1'b0;
      ddc_write <= 1'b0;
      ddc_addr  <= 20'h00000;
      ddc_wdata <= 8'h00;
    end else begin
      aux_ack <= 1'b0;
      ddc_req <= 1'b0;
      unique case (aux_state)
        AUX_IDLE: begin
          if (aux_req && aux_native) begin
            aux_ack   <= 1'b1;
            aux_rdata <= aux_write ? 8'h00 : dpcd_rd;
          end else if (aux_req) begin
            ddc_req   <= 1'b1;
            ddc_write <= aux_write;
            ddc_addr  <= aux_addr;
            ddc_wdata <= aux_wdata;
            aux_state <= AUX_DDC_WAIT;
          end
        end
        AUX_DDC_WAIT: begin
          if (ddc_done) begin
            aux_ack   <= 1'b1;
            aux_rdata <= ddc_write ? 8'h00 : ddc_rdata;
            aux_state <= AUX_IDLE;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Link controls and effective LVDS configuration (override or straps).
  logic       cfg_dual;
  fmt_t       cfg_fmt;
  logic [1:0] ovr_fmt_bits;

  assign ovr_fmt_bits = lvds_cfg[`LVDS_CFG_FMT_LSB +: 2];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enhanced_framing_en  <= 1'b0;
      alternate_seed_reset <= 1'b0;
      spread_enable        <= 1'b0;
      cfg_dual             <= 1'b0;
      cfg_fmt              <= FMT_VESA24;
    end else begin
      enhanced_framing_en  <= lane_set[`LANE_ENH_FRAME_BIT];
      alternate_seed_reset <= edp_set[`EDP_SET_ALTERNATE_SEED_RESET_BIT];
      spread_enable        <= lvds_cfg[`LVDS_CFG_SPREAD_BIT];
      if (lvds_cfg[`LVDS_CFG_OVR_BIT]) begin
        cfg_dual <= lvds_cfg[`LVDS_CFG_DUAL_BIT];
        cfg_fmt  <= (ovr_fmt_bits == 2'h3) ? FMT_DEPTH18 : fmt_t'(ovr_fmt_bits);
      end else begin
        cfg_dual <= strap_dual_q;
        cfg_fmt  <= strap_fmt_q;
      end
    end
  end

  // ========================================================================
  // Pixel clock domain. Reset is asserted at once and released in step with
  // the pixel clock. Configuration crosses as quasi-static levels through
  // two flops; it must only change while no video is streaming.
  logic       pix_rst_meta;
  logic       pix_rst_n;
  logic [2:0] cfg_meta;
  logic [2:0] cfg_pix;
  logic       dual_p;
  fmt_t       fmt_p;

  always_ff @(posedge pix_clk or negedge nrst) begin
    if (!nrst) begin
      pix_rst_meta <= 1'b0;
      pix_rst_n    <= 1'b0;
    end else begin
      pix_rst_meta <= 1'b1;
      pix_rst_n    <= pix_rst_meta;
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      cfg_meta <= 3'h0;
      cfg_pix  <= 3'h0;
    end else begin
      cfg_meta <= {cfg_fmt, cfg_dual};
      cfg_pix  <= cfg_meta;
    end
  end
  assign dual_p = cfg_pix[0];
  assign fmt_p  = (cfg_pix[2:1] == 2'h3) ? FMT_DEPTH18 : fmt_t'(cfg_pix[2:1]);

  // Packs one pixel into channels D,C,B,A (seven slots each, slot 6 first).
  function automatic logic [27:0] pack_pixel(
    input logic [7:0] red,
    input logic [7:0] green,
    input logic [7:0] blue,
    input logic       de,
    input logic       hs,
    input logic       vs,
    input fmt_t       fmt
  );
    logic [5:0] r6;
    logic [5:0] g6;
    logic [5:0] b6;
    logic [1:0] rx;
    logic [1:0] gx;
    logic [1:0] bx;
    logic [6:0] ch_d;
    if (fmt == FMT_MSB24) begin
      r6 = red[7:2];
      g6 = green[7:2];
      b6 = blue[7:2];
      rx = red[1:0];
      gx = green[1:0];
      bx = blue[1:0];
    end else begin
      r6 = red[5:0];
      g6 = green[5:0];
      b6 = blue[5:0];
      rx = red[7:6];
      gx = green[7:6];
      bx = blue[7:6];
    end
    // Channel D is absent at 18 bpp; all seven of its slots are driven low.
    ch_d = (fmt == FMT_DEPTH18) ? 7'h00 : {1'b0, bx, gx, rx};
    pack_pixel = {ch_d,
                  de, vs, hs, b6[5:2],
                  b6[1:0], g6[5:1],
                  g6[0], r6};
  endfunction : pack_pixel

  // Pixel pairing: in dual mode the first pixel of a pair waits, the second
  // completes the pair; the rising edge of DE restarts on the odd bus.
  logic [27:0] next_word;
  logic [27:0] held_odd;
  logic        pair_half;
  logic        de_prev;

  assign next_word = pack_pixel(pix_red, pix_green, pix_blue, pix_de, pix_hsync,
                                pix_vsync, fmt_p);

  // The path is purely synchronous to pix_clk, so any rate in range works.
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      held_odd        <= 28'h0000000;
      pair_half       <= 1'b0;
      de_prev         <= 1'b0;
      lvds_word_valid <= 1'b0;
      lvds_odd_word   <= 28'h0000000;
      lvds_even_word  <= 28'h0000000;
      lvds_clk_word   <= 7'h00;
    end else begin
      lvds_word_valid <= 1'b0;
      lvds_clk_word   <= `LVDS_CLK_WORD;
      if (pix_valid) begin
        de_prev <= pix_de;
        if (!dual_p) begin
          lvds_odd_word   <= next_word;
          lvds_even_word  <= 28'h0000000;
          lvds_word_valid <= 1'b1;
          pair_half       <= 1'b0;
        end else if (!pair_half || (pix_de && !de_prev)) begin
          held_odd  <= next_word;
          pair_half <= 1'b1;
        end else begin
          lvds_odd_word   <= held_odd;
          lvds_even_word  <= next_word;
          lvds_word_valid <= 1'b1;
          pair_half       <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Checks.
  chk_hpd_init_gate: assert property (@(posedge clk) disable iff (!nrst)
    hot_plug_output |-> init_done)
    else $error("hot-plug high before initialisation done");

  chk_strap_hold: assert property (@(posedge clk) disable iff (!nrst)
    !strap_sample |=> $stable(strap_lane_q) && $stable(strap_dual_q))
    else $error("strap settings changed outside a sample");

  chk_lane_select: assert property (@(posedge clk) disable iff (!nrst)
    strap_sample ##1 !strap_sample |=> lane_count_one == $past(pin_sync[0], 2))
    else $error("lane count does not follow sampled strap");

  chk_rev_read: assert property (@(posedge clk) disable iff (!nrst)
    aux_req && aux_native && !aux_write && aux_addr == `DPCD_REV_ADDR
      && aux_state == AUX_IDLE |=> aux_ack && aux_rdata == 8'h12)
    else $error("DPCD revision read wrong");

  chk_spread_cap: assert property (@(posedge clk) disable iff (!nrst)
    aux_req && aux_native && !aux_write && aux_addr == `DPCD_SPREAD_CAP_ADDR
      && aux_state == AUX_IDLE |=> aux_ack && aux_rdata[0])
    else $error("spread capability not reported");

  chk_spread_hold: assert property (@(posedge clk) disable iff (!nrst)
    dpcd_wr && aux_addr == `DPCD_SPREAD_CTRL_ADDR |=> spread_ctrl == $past(aux_wdata))
    else $error("spread control write not held");

  chk_vendor_write: assert property (@(posedge clk) disable iff (!nrst)
    dpcd_wr && aux_addr == 20'h00510 |=> lvds_cfg == $past(aux_wdata))
    else $error("vendor register not at base plus offset");

  chk_ddc_forward: assert property (@(posedge clk) disable iff (!nrst)
    aux_req && !aux_native && aux_state == AUX_IDLE |=> ddc_req && !aux_ack)
    else $error("I2C-over-AUX request not forwarded");

  chk_alternate_seed_reset_cap: assert property (@(posedge clk) disable iff (!nrst)
    aux_req && aux_native && !aux_write && aux_addr == `DPCD_EDP_CAP_ADDR
      && aux_state == AUX_IDLE |=> aux_rdata[0] ##0 aux_ack)
    else $error("seed reset capability missing");

  chk_chan_c_sync: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    pix_valid && !dual_p |=> lvds_word_valid
      && lvds_odd_word[20:18] == {$past(pix_de), $past(pix_vsync), $past(pix_hsync)})
    else $error("channel C sync slots wrong");

  chk_chan_a_red: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    pix_valid && !dual_p && fmt_p != FMT_MSB24 |=> lvds_odd_word[5:0] == $past(pix_red[5:0]))
    else $error("channel A red slots wrong");

  chk_depth18_d: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    pix_valid && fmt_p == FMT_DEPTH18 && !dual_p |=> lvds_odd_word[27:21] == 7'h00)
    else $error("channel D active at 18 bpp");

  cov_hpd_rise: cover property (@(posedge clk) disable iff (!nrst) $rose(hot_plug_output));
  cov_ddc_done: cover property (@(posedge clk) disable iff (!nrst)
    aux_state == AUX_DDC_WAIT && ddc_done);
  cov_dual_pair: cover property (@(posedge pix_clk) disable iff (!pix_rst_n)
    dual_p && lvds_word_valid);

endmodule : dp_to_lvds_pixel_packer

// *** ddc_partner.sv ***
/*
  Behavioural DDC master that answers forwarded I2C-over-AUX requests.
  Assumes one-cycle request pulses on clk and an active-low reset.
*/
module ddc_partner #(
  parameter int DELAY = 3
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ddc_req,
  input  wire logic [19:0] ddc_addr,
  output logic             ddc_done,
  output logic [7:0]       ddc_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ==========================================================================
  // Answer after DELAY cycles; idle data toggles so stale bytes never match.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt       <= 0;
      ddc_done  <= 1'b0;
      ddc_rdata <= 8'h00;
    end else begin
      ddc_done  <= 1'b0;
      ddc_rdata <= ~ddc_rdata;
      if (ddc_req) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        cnt       <= 0;
        ddc_done  <= 1'b1;
        ddc_rdata <= ddc_addr[7:0] ^ 8'h5A;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : ddc_partner

// *** tb_top.sv ***
/*
  Self-checking bench for the pixel packer: AUX accesses, straps, packing.
  Assumes the packer and the DDC partner model are compiled before it.
*/
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
`define WAITC(ck, cond) begin int k; for (k = 0; k < 60 && !(cond); k++) begin \
  @(posedge ck); #1; end if (!(cond)) begin n_errors++; end_sim(); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dp_lvds_pkg::*;
  logic        clk = 0, pix_clk = 0, nrst = 0, lane_count_strap = 1;
  logic        bus_count_strap = 0, deep_sleep_exit = 0, aux_req = 0, aux_native = 0;
  logic        aux_write = 0, pix_valid = 0, pix_de = 0, pix_hsync = 0, pix_vsync = 0;
  logic [1:0]  format_depth_strap = 2'h0;
  logic [19:0] aux_addr = 20'h00000;
  logic [7:0]  aux_wdata = 8'h00, pix_red = 8'h00, pix_green = 8'h00, pix_blue = 8'h00;
  logic        hot_plug_output, lane_count_one, enhanced_framing_en, alternate_seed_reset;
  logic        spread_enable, aux_ack, ddc_req, ddc_done, lvds_word_valid, ddc_write;
  logic [7:0]  aux_rdata, ddc_rdata, ddc_wdata;
  logic [19:0] ddc_addr;
  logic [27:0] lvds_odd_word, lvds_even_word;
  logic [6:0]  lvds_clk_word;
  int          n_errors = 0, checked = 0;

  // ==========================================================================
  // Clocks: the pixel clock is unrelated to the system clock.
  always #20 clk = ~clk;
  always #24 pix_clk = ~pix_clk;

  // ==========================================================================
  // Device under test with a short start-up count, and its DDC partner.
  dp_to_lvds_pixel_packer #(.INIT_CYCLES(20)) dp_to_lvds_pixel_packer_i (
    .clk, .nrst, .lane_count_strap, .bus_count_strap, .format_depth_strap,
    .deep_sleep_exit, .hot_plug_output, .lane_count_one, .enhanced_framing_en,
    .alternate_seed_reset, .spread_enable, .aux_req, .aux_native, .aux_write,
    .aux_addr, .aux_wdata, .aux_ack, .aux_rdata, .ddc_req, .ddc_write,
    .ddc_addr, .ddc_wdata, .ddc_done, .ddc_rdata, .pix_clk, .pix_valid,
    .pix_red, .pix_green, .pix_blue, .pix_de, .pix_hsync, .pix_vsync,
    .lvds_word_valid, .lvds_odd_word, .lvds_even_word, .lvds_clk_word);
  ddc_partner ddc_partner_i (.clk, .nrst, .ddc_req, .ddc_addr, .ddc_done, .ddc_rdata);

  // ==========================================================================
  // Expected packing, built from the slot tables; slot 6 of D reads as zero.
  function automatic logic [27:0] pack(input logic [7:0] r, g, b,
                                       input logic de, vs, hs, input fmt_t f);
    logic       m;
    logic [5:0] r6, g6, b6;
    logic [6:0] d;
    m  = (f == FMT_MSB24);
    r6 = m ? r[7:2] : r[5:0];
    g6 = m ? g[7:2] : g[5:0];
    b6 = m ? b[7:2] : b[5:0];
    d  = m ? {1'b0, b[1:0], g[1:0], r[1:0]} : {1'b0, b[7:6], g[7:6], r[7:6]};
    if (f == FMT_DEPTH18) d = 7'h00;
    return {d, de, vs, hs, b6[5:2], b6[1:0], g6[5:1], g6[0], r6};
  endfunction : pack

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // One AUX byte; qualifiers stand until the answer is seen.
  task automatic aux(input logic nat, wr, input logic [19:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    {aux_req, aux_native, aux_write, aux_addr, aux_wdata} <= {1'b1, nat, wr, a, d};
    @(posedge clk);
    aux_req <= 1'b0;
    #1;
    `WAITC(clk, aux_ack === 1'b1)
    q = aux_rdata;
  endtask : aux

  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    logic [7:0] q;
    aux(1'b1, 1'b0, a, 8'h00, q);
    `CHK("aux_rdata", e, q)
  endtask : rd

  task automatic pix(input logic [7:0] r, g, b, input logic de, vs, hs);
    @(posedge pix_clk);
    {pix_valid, pix_red, pix_green, pix_blue, pix_de, pix_vsync, pix_hsync} <=
      {1'b1, r, g, b, de, vs, hs};
  endtask : pix

  // Stop the stream, then wait for the packed word pulse.
  task automatic word();
    @(posedge pix_clk);
    pix_valid <= 1'b0;
    #1;
    `WAITC(pix_clk, lvds_word_valid === 1'b1)
  endtask : word

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [7:0]  q;
    logic [27:0] exp_word;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    `CHK("hot_plug_output", 1'b0, hot_plug_output)
    `WAITC(clk, hot_plug_output === 1'b1)
    `CHK("lane_count_one", 1'b1, lane_count_one)
    `CHK("lvds_clk_word", 7'h63, lvds_clk_word)
    rd(20'h00000, 8'h12);
    rd(20'h00002, 8'h82);
    rd(20'h00003, 8'h01);
    rd(20'h00511, 8'h01);
    rd(20'h00050, 8'h00);
    aux(1'b1, 1'b1, 20'h00107, 8'h11, q);
    `CHK("aux_rdata", 8'h00, q)
    rd(20'h00107, 8'h11);
    aux(1'b1, 1'b1, 20'h00101, 8'h80, q);
    aux(1'b1, 1'b1, 20'h0010A, 8'h01, q);
    // The capability read also gives the registered controls time to follow.
    rd(20'h0000D, 8'h01);
    `CHK("enhanced_framing_en", 1'b1, enhanced_framing_en)
    `CHK("alternate_seed_reset", 1'b1, alternate_seed_reset)
    aux(1'b0, 1'b0, 20'h00034, 8'h00, q);
    `CHK("ddc_rdata", 8'h6E, q)
    aux(1'b0, 1'b1, 20'h00050, 8'hA5, q);
    `CHK("ddc_write", 1'b1, ddc_write)
    `CHK("ddc_wdata", 8'hA5, ddc_wdata)
    `CHK("aux_rdata", 8'h00, q)
    // Every packing in single-bus mode, chosen through the override register.
    for (int f = 0; f < 3; f++) begin
      aux(1'b1, 1'b1, 20'h00510, {4'h0, 1'b1, 2'(f), 1'b0}, q);
      repeat (8) @(posedge pix_clk);
      pix(8'hC5, 8'h3A, 8'h96, 1'(f == 1), 1'b0, 1'b1);
      word();
      exp_word = pack(8'hC5, 8'h3A, 8'h96, 1'(f == 1), 1'b0, 1'b1, fmt_t'(f));
      `CHK("odd", exp_word, lvds_odd_word)
      `CHK("even", 28'h0000000, lvds_even_word)
    end
    aux(1'b1, 1'b1, 20'h00510, 8'h1B, q);
    rd(20'h00510, 8'h1B);
    repeat (8) @(posedge pix_clk);
    `CHK("spread_enable", 1'b1, spread_enable)
    // One pixel per pixel clock keeps the payload inside both link budgets.
    pix(8'h81, 8'h42, 8'h24, 1'b1, 1'b1, 1'b0);
    pix(8'h7E, 8'hBD, 8'hDB, 1'b1, 1'b1, 1'b0);
    word();
    exp_word = pack(8'h81, 8'h42, 8'h24, 1'b1, 1'b1, 1'b0, FMT_MSB24);
    `CHK("odd", exp_word, lvds_odd_word)
    exp_word = pack(8'h7E, 8'hBD, 8'hDB, 1'b1, 1'b1, 1'b0, FMT_MSB24);
    `CHK("even", exp_word, lvds_even_word)
    // A strap change acts only when deep-sleep exit resamples it.
    @(posedge clk);
    lane_count_strap <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK("lane_count_one", 1'b1, lane_count_one)
    @(posedge clk);
    deep_sleep_exit <= 1'b1;
    repeat (4) @(posedge clk);
    deep_sleep_exit <= 1'b0;
    `WAITC(clk, lane_count_one === 1'b0)
    `CHK("hot_plug_output", 1'b0, hot_plug_output)
    `WAITC(clk, hot_plug_output === 1'b1)
    rd(20'h00002, 8'h84);
    rd(20'h00511, 8'h00);
    end_sim();
  end
endmodule : tb_top
